// File: hdl/chopper_defines.svh
// Field widths, reset values and divider counts of the chopper.
// Assumes inclusion by bare name from the design files.
`ifndef CHOPPER_DEFINES_SVH
`define CHOPPER_DEFINES_SVH

// ----------------------------------------------------------------------
// Divider periods in system clock cycles
// ----------------------------------------------------------------------
`define DIV_SEL0 11'h400
`define DIV_SEL1 11'h2ab
`define DIV_SEL2 11'h200
`define DIV_SEL3 11'h19a

// ----------------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------------
`define AMP_W 8
`define CNT_W 11
`define GRAD_RST 8'h01
`define OFS_RST 8'h80
`define SCALE_RST 8'h00

`endif

// File: hdl/chopper_pkg.sv
// Types shared by the chopper design files.
// Assumes chopper_defines.svh is reachable on the include path.
package chopper_pkg;
    `include "chopper_defines.svh"

    typedef enum logic [1:0] {
        SS_NORMAL = 2'h0,
        SS_STANDSTILL_OPTION = 2'h1,
        SS_SHORT_LOW = 2'h2,
        SS_SHORT_HIGH = 2'h3
    } standstill_t;

    typedef struct packed {
        logic [1:0] pwm_divider_select;
        logic [`AMP_W-1:0] amplitude_gradient;
        logic [`AMP_W-1:0] amplitude_offset;
        logic symmetric;
    } cycle_cfg_t;

    typedef struct packed {
        logic low_a;
        logic high_a;
        logic low_b;
        logic high_b;
    } coil_gate_t;
endpackage

// File: hdl/pwm_period_counter.sv
// PWM period counter: counts one period and flags its last cycle.
// Assumes the period is chosen by the parent and held stable per cycle.
module pwm_period_counter #(
    parameter int CNT_W = 11
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Period control
    input wire logic [CNT_W-1:0] i_period,
    input wire logic i_run,
    // Position
    output logic [CNT_W-1:0] o_count,
    output logic o_wrap
);
    typedef struct packed {
        logic [CNT_W-1:0] count;
    } cnt_state_t;

    cnt_state_t state_ff;
    cnt_state_t nxt_state;

    // Elaboration refuses a counter too narrow for the longest period.
    if (CNT_W < 11) begin : g_width_check
        $error("CNT_W too small for the longest period");
    end

    assign o_wrap = i_run && (state_ff.count == i_period - 1'b1);
    assign o_count = state_ff.count;

    always_comb begin
        nxt_state = state_ff;
        if (!i_run || o_wrap) begin
            nxt_state.count = '0;
        end else begin
            nxt_state.count = state_ff.count + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    a_wrap_spacing: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        o_wrap |=> !o_wrap)
        else $error("Wrap flagged on consecutive cycles.");
endmodule

// File: hdl/pwm_chopper.sv
// Quiet voltage-mode PWM chopper: divider, amplitude scaling, standstill.
// Assumes all configuration inputs are synchronous to i_clk_sys.
`include "chopper_defines.svh"

module pwm_chopper
    import chopper_pkg::*;
#(
    parameter int AMP_W = 8,
    parameter int CNT_W = 11
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Configuration
    input wire logic i_pwm_autoscale,
    input wire chopper_pkg::cycle_cfg_t i_cfg,
    input wire chopper_pkg::standstill_t i_standstill_option,
    input wire logic [3:0] i_driver_off_time_enable,
    input wire logic i_quiet_enable,
    input wire logic i_hold_current_zero,
    input wire logic i_standstill,
    // Motion and sensing
    input wire logic [AMP_W-1:0] i_velocity,
    input wire logic [AMP_W-1:0] i_duty_a,
    input wire logic [AMP_W-1:0] i_duty_b,
    input wire logic i_current_high,
    // Bridge and status
    output chopper_pkg::coil_gate_t o_gates,
    output logic [AMP_W-1:0] o_pwm_scale,
    output logic o_cycle_start
);
    import chopper_pkg::*;

    typedef struct packed {
        cycle_cfg_t cfg;
        logic [AMP_W-1:0] scale;
        coil_gate_t gates;
    } chop_state_t;

    chop_state_t state_ff;
    chop_state_t nxt_state;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] count;
    logic wrap;
    logic enabled;
    logic brake_active;
    logic [AMP_W-1:0] target;
    logic [CNT_W-1:0] pos;

    // Elaboration refuses an amplitude width other than 8 and a counter too narrow for the fixed periods.
    if (AMP_W != `AMP_W || CNT_W < `CNT_W) begin : g_width_check
        $error("Unsupported amplitude or counter width");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [CNT_W-1:0] div_period(input logic [1:0] sel);
        case (sel)
            2'h0: div_period = CNT_W'(`DIV_SEL0);
            2'h1: div_period = CNT_W'(`DIV_SEL1);
            2'h2: div_period = CNT_W'(`DIV_SEL2);
            default: div_period = CNT_W'(`DIV_SEL3);
        endcase
    endfunction

    function automatic logic [AMP_W-1:0] sat_add(input logic [AMP_W:0] v);
        sat_add = v[AMP_W] ? '1 : v[AMP_W-1:0];
    endfunction

    function automatic logic pwm_on(input logic [CNT_W-1:0] p,
                                    input logic [AMP_W-1:0] duty,
                                    input logic [AMP_W-1:0] amp);
        logic [2*AMP_W-1:0] prod;
        prod = duty * amp;
        pwm_on = {3'h0, p[CNT_W-1:3]} < CNT_W'(prod[2*AMP_W-1:AMP_W]);
    endfunction

    // ------------------------------------------------------------------
    // Period counter
    // ------------------------------------------------------------------
    assign enabled = (i_driver_off_time_enable != 4'h0);
    assign period = div_period(state_ff.cfg.pwm_divider_select);

    pwm_period_counter #(
        .CNT_W(CNT_W)
    ) u_period (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_period(period),
        .i_run(enabled),
        .o_count(count),
        .o_wrap(wrap)
    );

    // ------------------------------------------------------------------
    // Amplitude and gates
    // ------------------------------------------------------------------
    // Symmetric mode folds the count so both halves mirror; otherwise
    // the pulse is left-aligned.
    always_comb begin
        pos = count;
        if (state_ff.cfg.symmetric && count >= (period >> 1)) begin
            pos = period - count - 1'b1;
        end
        if (state_ff.cfg.symmetric) begin
            pos = pos << 1;
        end
    end

    assign brake_active = i_standstill && i_hold_current_zero &&
                          i_quiet_enable;

    always_comb begin
        logic [2*AMP_W-1:0] slope;
        slope = i_velocity * state_ff.cfg.amplitude_gradient;
        target = sat_add({1'b0, state_ff.cfg.amplitude_offset} +
                         {1'b0, slope[AMP_W-1:0]});
    end

    always_comb begin
        logic on_a;
        logic on_b;
        on_a = 1'b0;
        on_b = 1'b0;
        nxt_state = state_ff;
        if (wrap || !enabled) begin
            nxt_state.cfg = i_cfg;
        end
        if (wrap) begin
            if (!i_pwm_autoscale) begin
                nxt_state.scale = target;
            end else if (i_current_high) begin
                // Regulation loop: gradient is the step size.
                nxt_state.scale =
                    (state_ff.scale > state_ff.cfg.amplitude_gradient)
                    ? state_ff.scale - state_ff.cfg.amplitude_gradient : '0;
            end else begin
                nxt_state.scale = sat_add({1'b0, state_ff.scale} +
                    {1'b0, state_ff.cfg.amplitude_gradient});
            end
            if (i_pwm_autoscale &&
                nxt_state.scale > state_ff.cfg.amplitude_offset) begin
                nxt_state.scale = state_ff.cfg.amplitude_offset;
            end
        end
        on_a = pwm_on(pos, i_duty_a, state_ff.scale);
        on_b = pwm_on(pos, i_duty_b, state_ff.scale);
        nxt_state.gates = '0;
        if (!enabled) begin
            nxt_state.gates = '0;
        end else if (brake_active) begin
            case (i_standstill_option)
                SS_NORMAL: nxt_state.gates = '{!on_a, on_a, !on_b, on_b};
                SS_STANDSTILL_OPTION: nxt_state.gates = '0;
                SS_SHORT_LOW: nxt_state.gates = '{1'b1, 1'b0, 1'b1, 1'b0};
                SS_SHORT_HIGH: nxt_state.gates = '{1'b0, 1'b1, 1'b0, 1'b1};
                default: nxt_state.gates = '0;
            endcase
        end else begin
            nxt_state.gates = '{!on_a, on_a, !on_b, on_b};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_ff.cfg <= '{2'h0, `GRAD_RST, `OFS_RST, 1'b0};
            state_ff.scale <= `SCALE_RST;
            state_ff.gates <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign o_gates = state_ff.gates;
    assign o_pwm_scale = state_ff.scale;
    assign o_cycle_start = wrap;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_driver_off: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !enabled |=> o_gates == '0)
        else $error("Gates active while driver disabled.");
    a_cfg_held: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        enabled && $past(enabled) && !$past(wrap) |-> $stable(state_ff.cfg))
        else $error("Configuration changed mid-cycle.");
    a_cfg_taken: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wrap |=> state_ff.cfg == $past(i_cfg))
        else $error("Configuration not taken at boundary.");
    a_sel0_period: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff.cfg.pwm_divider_select == 2'h0 |-> period == 11'h400)
        else $error("Selection zero period wrong.");
    a_sel_periods: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        state_ff.cfg.pwm_divider_select == 2'h3 |-> period == 11'h19a)
        else $error("Selection three period wrong.");
    a_low_short: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        enabled && brake_active && i_standstill_option == SS_SHORT_LOW
        |=> o_gates == 4'b1010)
        else $error("Low-side short not applied.");
    a_high_short: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        enabled && brake_active && i_standstill_option == SS_SHORT_HIGH
        |=> o_gates == 4'b0101)
        else $error("High-side short not applied.");
    a_no_brake_run: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        enabled && !i_quiet_enable |=> o_gates.low_a != o_gates.high_a)
        else $error("Brake applied outside quiet mode.");
    a_forward_scale: assert property (@(posedge i_clk_sys)
        disable iff (i_reset)
        wrap && !i_pwm_autoscale |=> o_pwm_scale == $past(target))
        else $error("Forward amplitude not loaded.");
    a_scale_limit: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wrap && i_pwm_autoscale
        |=> o_pwm_scale <= $past(state_ff.cfg.amplitude_offset))
        else $error("Regulated scale above limit.");
    a_scale_hold: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !wrap |=> $stable(o_pwm_scale))
        else $error("Scale changed mid-cycle.");

    c_wrap: cover property (@(posedge i_clk_sys) disable iff (i_reset) wrap);
    c_autoscale: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        wrap && i_pwm_autoscale);
    c_brake: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        enabled && brake_active);
    c_symmetric: cover property (@(posedge i_clk_sys) disable iff (i_reset)
        wrap && state_ff.cfg.symmetric);
endmodule

// File: test/coil_model.sv
// Behavioural model of one coil pair behind the power bridges.
// Assumes the gate commands are registered by the chopper on i_clk_sys.
module coil_model #(
    parameter int LEVEL_MAX = 255,
    parameter int TARGET = 128
) (
    // Clock and bridge
    input wire logic i_clk_sys,
    input wire chopper_pkg::coil_gate_t i_gates,
    // Test control: 0 natural, 1 always above target, 2 always below
    input wire logic [1:0] i_force,
    // Sense
    output logic o_current_high
);
    timeunit 1ns;
    timeprecision 1ps;
    int level = 0;

    // Current rises only while the coil A high side and the coil B low side are both on, else it decays.
    always @(posedge i_clk_sys) begin
        if (i_gates.high_a && i_gates.low_b && level < LEVEL_MAX) begin
            level <= level + 1;
        end else if (level > 0) begin
            level <= level - 1;
        end
    end

    // The regulator compare is the only feedback the chopper sees.
    assign o_current_high = (i_force == 2'h1) ? 1'b1 :
                            (i_force == 2'h2) ? 1'b0 : (level > TARGET);
endmodule

// File: test/tb_top.sv
// Self-checking bench for the quiet PWM chopper.
// Assumes a synchronous active-high reset and one 50 MHz clock.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import chopper_pkg::*;
    logic clk = 1'b0, reset = 1'b1, autoscale = 1'b0, quiet = 1'b1;
    logic hold_zero = 1'b0, standstill = 1'b0, cur_high;
    logic [3:0] driver_off_time_enable = 4'h0;
    logic [1:0] force_mode = 2'h0;
    logic [7:0] vel = 8'h10, a, b;
    cycle_cfg_t cfg = '{2'h0, 8'h04, 8'h30, 1'b0};
    standstill_t ss_opt = SS_NORMAL;
    coil_gate_t gates;
    logic [7:0] scale;
    logic cyc, last;
    int failures = 0, compares = 0, n;
    logic [15:0] periods [4] = '{16'h400, 16'h2ab, 16'h200, 16'h19a};
    // At zero scale normal operation leaves both low sides on.
    coil_gate_t brake [4] = '{4'ha, 4'h0, 4'ha, 4'h5};

    always #10 clk = ~clk;

    pwm_chopper dut (.i_clk_sys(clk), .i_reset(reset),
        .i_pwm_autoscale(autoscale), .i_cfg(cfg),
        .i_standstill_option(ss_opt), .i_driver_off_time_enable(driver_off_time_enable),
        .i_quiet_enable(quiet), .i_hold_current_zero(hold_zero),
        .i_standstill(standstill), .i_velocity(vel), .i_duty_a(8'h80),
        .i_duty_b(8'h40), .i_current_high(cur_high), .o_gates(gates),
        .o_pwm_scale(scale), .o_cycle_start(cyc));
    coil_model coil (.i_clk_sys(clk), .i_gates(gates),
        .i_force(force_mode), .o_current_high(cur_high));

    task automatic chk_num(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_gates(input coil_gate_t got, input coil_gate_t exp);
        chk_num({12'h000, got}, {12'h000, exp});
    endtask

    // Counts edges up to and including the one that shows the wrap pulse.
    task automatic wait_wrap(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (cyc !== 1'b1 && cnt < 2000);
    endtask

    task automatic wraps(input int k);
        repeat (k) wait_wrap(n);
    endtask

    // Counts edges with the coil A high side on over one whole period.
    task automatic count_on(output int on, output logic last_on);
        int k;
        on = 0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
            on += int'(gates.high_a);
        end while (cyc !== 1'b1 && k < 2000);
        last_on = gates.high_a;
    endtask

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        // The tests need about 45,000 cycles; this leaves a wide margin.
        #1200000;
        failures++;
        test_done();
    end

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk_gates(gates, 4'h0);
        chk_num({8'h00, scale}, 16'h0000);
        @(posedge clk);
        driver_off_time_enable <= 4'hf;
        wait_wrap(n);
        wait_wrap(n);
        chk_num(16'(n), periods[0]);
        // A divider change just after a wrap must not shorten that cycle.
        for (int s = 1; s < 4; s++) begin
            @(posedge clk);
            cfg.pwm_divider_select <= 2'(s);
            wait_wrap(n);
            chk_num(16'(n + 1), periods[s - 1]);
            wait_wrap(n);
            chk_num(16'(n), periods[s]);
        end
        wraps(2);
        chk_num({8'h00, scale}, 16'h0070);
        // Scale 0x70 gives 448 of 1024 on cycles in both alignments;
        // only the centred pulse is still on next to the period end.
        @(posedge clk);
        cfg.pwm_divider_select <= 2'h0;
        wraps(2);
        count_on(n, last);
        chk_num(16'(n), 16'h01c0);
        chk_num({15'h0000, last}, 16'h0000);
        @(posedge clk);
        cfg.symmetric <= 1'b1;
        wraps(2);
        count_on(n, last);
        chk_num(16'(n), 16'h01c0);
        chk_num({15'h0000, last}, 16'h0001);
        @(posedge clk);
        driver_off_time_enable <= 4'h1;
        cfg.symmetric <= 1'b0;
        vel <= 8'hff;
        cfg.amplitude_gradient <= 8'hff;
        cfg.amplitude_offset <= 8'hff;
        wraps(3);
        chk_num({8'h00, scale}, 16'h00ff);
        @(posedge clk);
        autoscale <= 1'b1;
        cfg.amplitude_gradient <= 8'h10;
        cfg.amplitude_offset <= 8'h50;
        wraps(4);
        force_mode <= 2'h2;
        wraps(12);
        chk_num({8'h00, scale}, 16'h0050);
        force_mode <= 2'h1;
        wraps(2);
        a = scale;
        wraps(1);
        b = scale;
        chk_num({8'h00, a - b}, 16'h0010);
        wraps(8);
        chk_num({8'h00, scale}, 16'h0000);
        @(posedge clk);
        standstill <= 1'b1;
        hold_zero <= 1'b1;
        for (int o = 0; o < 4; o++) begin
            @(posedge clk);
            ss_opt <= standstill_t'(o);
            repeat (3) @(posedge clk);
            #1;
            chk_gates(gates, brake[o]);
        end
        // The high-side short must drop out without quiet mode or
        // with a nonzero hold current.
        @(posedge clk);
        quiet <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_gates(gates, 4'ha);
        @(posedge clk);
        quiet <= 1'b1;
        hold_zero <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk_gates(gates, 4'ha);
        @(posedge clk);
        driver_off_time_enable <= 4'h0;
        repeat (3) @(posedge clk);
        #1;
        chk_gates(gates, 4'h0);
        test_done();
    end
endmodule
